// ===== vsp_pkg.sv
package vsp_pkg;

    // ------------------------------------------------------------
    // widths and build-time defaults
    // ------------------------------------------------------------
    localparam int VSP_DATA_W      = 12;    // sensor component width
    localparam int VSP_DIM_W       = 13;    // pixel and line counters
    localparam int VSP_PHASE_W     = 2;     // colour grid phase
    localparam int VSP_LINE_LEN    = 640;   // active pixels per line
    localparam int VSP_LINE_CNT    = 480;   // active lines per frame
    localparam int VSP_PHASE       = 0;     // starting grid phase
    localparam int VSP_RST_MIN_CYC = 32;    // minimum reset hold, cycles

    // ------------------------------------------------------------
    // grid sites, after phase is applied
    // ------------------------------------------------------------
    localparam logic [1:0] VSP_SITE_RED  = 2'h0;
    localparam logic [1:0] VSP_SITE_BLUE = 2'h3;

    // output slot state
    typedef enum logic {VSP_SLOT_EMPTY, VSP_SLOT_FULL} vsp_slot_e;

    // round a bit count up to a whole number of bytes
    function automatic int vsp_pad8(input int bits);
        return ((bits + 7) / 8) * 8;
    endfunction

endpackage

// ===== vsp_ctl_port.sv
`timescale 1ns/10ps
module vsp_ctl_port
#(
    parameter int LINE_LEN = vsp_pkg::VSP_LINE_LEN,
    parameter int LINE_CNT = vsp_pkg::VSP_LINE_CNT,
    parameter int PHASE    = vsp_pkg::VSP_PHASE
)
(
    input  wire logic                            clk,
    input  wire logic                            srst,
    input  wire logic                            ctl_clk,
    input  wire logic                            ctl_clk_en,
    input  wire logic                            ctl_rst_n,
    input  wire logic [vsp_pkg::VSP_DIM_W-1:0]   ctl_line_len,
    input  wire logic [vsp_pkg::VSP_DIM_W-1:0]   ctl_line_cnt,
    input  wire logic [vsp_pkg::VSP_PHASE_W-1:0] ctl_phase,
    output logic      [vsp_pkg::VSP_DIM_W-1:0]   act_line_len,
    output logic      [vsp_pkg::VSP_DIM_W-1:0]   act_line_cnt,
    output logic      [vsp_pkg::VSP_PHASE_W-1:0] act_phase,
    output logic                                 ctl_rst_sync
);
    import vsp_pkg::*;

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    localparam logic [VSP_DIM_W-1:0]   LEN_RST = VSP_DIM_W'(LINE_LEN);
    localparam logic [VSP_DIM_W-1:0]   CNT_RST = VSP_DIM_W'(LINE_CNT);
    localparam logic [VSP_PHASE_W-1:0] PH_RST  = VSP_PHASE_W'(PHASE);

    logic                   ctl_clk_d_r, ctl_clk_d_nxt;  // edge history
    logic [VSP_DIM_W-1:0]   len_r, len_nxt;              // line length
    logic [VSP_DIM_W-1:0]   cnt_r, cnt_nxt;              // line count
    logic [VSP_PHASE_W-1:0] ph_r, ph_nxt;                // grid phase
    logic                   rst_hold_r, rst_hold_nxt;    // reset seen
    logic                   sync1_r, sync2_r;            // resync chain
    logic                   edge_w;

    // rising control clock edge; the control clock is a plain input
    assign edge_w = ctl_clk & ~ctl_clk_d_r;

    // next values: act only on control clock edges
    always_comb
    begin
        ctl_clk_d_nxt = ctl_clk;
        len_nxt       = len_r;
        cnt_nxt       = cnt_r;
        ph_nxt        = ph_r;
        rst_hold_nxt  = rst_hold_r;
        if (edge_w)
        begin
            if (!ctl_rst_n)
            begin
                // reset wins even with enable low
                len_nxt      = LEN_RST;
                cnt_nxt      = CNT_RST;
                ph_nxt       = PH_RST;
                rst_hold_nxt = 1'b1;
            end
            else if (ctl_clk_en)
            begin
                // inputs only sampled while enabled
                len_nxt      = ctl_line_len;
                cnt_nxt      = ctl_line_cnt;
                ph_nxt       = ctl_phase;
                rst_hold_nxt = 1'b0;
            end
            else
            begin
                // enable low: state frozen, reset cleared only
                rst_hold_nxt = 1'b0;
            end
        end
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctl_clk_d_r <= 1'b1;    // no false edge at release
            len_r       <= LEN_RST;
            cnt_r       <= CNT_RST;
            ph_r        <= PH_RST;
            rst_hold_r  <= 1'b0;
            sync1_r     <= 1'b0;
            sync2_r     <= 1'b0;
        end
        else
        begin
            ctl_clk_d_r <= ctl_clk_d_nxt;
            len_r       <= len_nxt;
            cnt_r       <= cnt_nxt;
            ph_r        <= ph_nxt;
            rst_hold_r  <= rst_hold_nxt;
            // resync into the stream domain
            sync1_r     <= rst_hold_r;
            sync2_r     <= sync1_r;
        end
    end

    // outputs straight from flops
    assign act_line_len = len_r;
    assign act_line_cnt = cnt_r;
    assign act_phase    = ph_r;
    assign ctl_rst_sync = sync2_r;

endmodule

// ===== vsp_interp.sv
`timescale 1ns/10ps
module vsp_interp
#(
    parameter int DATA_W = vsp_pkg::VSP_DATA_W
)
(
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            take,
    input  wire logic                            sof,
    input  wire logic                            line_end_marker,
    input  wire logic [DATA_W-1:0]               sample,
    input  wire logic [vsp_pkg::VSP_PHASE_W-1:0] phase,
    output logic      [3*DATA_W-1:0]             rgb
);
    import vsp_pkg::*;

    // ------------------------------------------------------------
    // held components and grid position
    // ------------------------------------------------------------
    logic [DATA_W-1:0] red_r, red_nxt;      // last red seen
    logic [DATA_W-1:0] grn_r, grn_nxt;      // last green seen
    logic [DATA_W-1:0] blu_r, blu_nxt;      // last blue seen
    logic              xp_r, xp_nxt;        // column parity
    logic              yp_r, yp_nxt;        // row parity
    logic              xp_w, yp_w;
    logic [1:0]        site_w;

    // a frame start forces position back to the grid origin
    assign xp_w   = sof ? 1'b0 : xp_r;
    assign yp_w   = sof ? 1'b0 : yp_r;
    assign site_w = {yp_w, xp_w} ^ phase;

    // nearest-neighbour fill: cheap, but smears edges
    always_comb
    begin
        red_nxt = red_r;
        grn_nxt = grn_r;
        blu_nxt = blu_r;
        xp_nxt  = xp_r;
        yp_nxt  = yp_r;
        if (take)
        begin
            unique case (site_w)
                VSP_SITE_RED:  red_nxt = sample;
                VSP_SITE_BLUE: blu_nxt = sample;
                default:       grn_nxt = sample;
            endcase
            xp_nxt = line_end_marker ? 1'b0 : ~xp_w;
            yp_nxt = line_end_marker ? ~yp_w : yp_w;
        end
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            red_r <= '0;
            grn_r <= '0;
            blu_r <= '0;
            xp_r  <= 1'b0;
            yp_r  <= 1'b0;
        end
        else
        begin
            red_r <= red_nxt;
            grn_r <= grn_nxt;
            blu_r <= blu_nxt;
            xp_r  <= xp_nxt;
            yp_r  <= yp_nxt;
        end
    end

    // packed output as it will be after this beat: red low
    assign rgb = {blu_nxt, grn_nxt, red_nxt};

endmodule

// ===== vsp_top.sv
`timescale 1ns/10ps
module vsp_top
#(
    parameter int DATA_W   = vsp_pkg::VSP_DATA_W,
    parameter bit HAS_CTRL = 1'b1,
    parameter int LINE_LEN = vsp_pkg::VSP_LINE_LEN,
    parameter int LINE_CNT = vsp_pkg::VSP_LINE_CNT,
    parameter int PHASE    = vsp_pkg::VSP_PHASE,
    parameter int IN_W     = vsp_pkg::vsp_pad8(DATA_W),
    parameter int OUT_W    = vsp_pkg::vsp_pad8(3 * DATA_W)
)
(
    input  wire logic                            clk,
    input  wire logic                            srst,
    input  wire logic                            stream_clk_en,
    input  wire logic [IN_W-1:0]                 in_data,
    input  wire logic                            in_valid,
    output logic                                 in_ready,
    input  wire logic                            in_frame_start_flag,
    input  wire logic                            in_line_end_marker,
    output logic      [OUT_W-1:0]                out_data,
    output logic                                 out_valid,
    input  wire logic                            out_ready,
    output logic                                 out_frame_start_flag,
    output logic                                 out_line_end_marker,
    output logic                                 line_len_err,
    output logic                                 frame_len_err,
    input  wire logic                            ctl_clk,
    input  wire logic                            ctl_clk_en,
    input  wire logic                            ctl_rst_n,
    input  wire logic [vsp_pkg::VSP_DIM_W-1:0]   ctl_line_len,
    input  wire logic [vsp_pkg::VSP_DIM_W-1:0]   ctl_line_cnt,
    input  wire logic [vsp_pkg::VSP_PHASE_W-1:0] ctl_phase
);
    import vsp_pkg::*;

    // ------------------------------------------------------------
    // configuration source
    // ------------------------------------------------------------
    logic [VSP_DIM_W-1:0]   cp_len, cp_cnt;     // control port values
    logic [VSP_PHASE_W-1:0] cp_ph;
    logic                   cp_rst;             // resynced control reset
    logic [VSP_DIM_W-1:0]   cfg_len, cfg_cnt;   // values in use
    logic [VSP_PHASE_W-1:0] cfg_ph;
    logic                   rst_w;              // stream-side reset

    vsp_ctl_port #(
        .LINE_LEN     (LINE_LEN),
        .LINE_CNT     (LINE_CNT),
        .PHASE        (PHASE)
    ) u_ctl (
        .clk          (clk),
        .srst         (srst),
        .ctl_clk      (ctl_clk),
        .ctl_clk_en   (ctl_clk_en),
        .ctl_rst_n    (ctl_rst_n),
        .ctl_line_len (ctl_line_len),
        .ctl_line_cnt (ctl_line_cnt),
        .ctl_phase    (ctl_phase),
        .act_line_len (cp_len),
        .act_line_cnt (cp_cnt),
        .act_phase    (cp_ph),
        .ctl_rst_sync (cp_rst)
    );

    // without a control port geometry is frozen at build
    assign cfg_len = HAS_CTRL ? cp_len : VSP_DIM_W'(LINE_LEN);
    assign cfg_cnt = HAS_CTRL ? cp_cnt : VSP_DIM_W'(LINE_CNT);
    assign cfg_ph  = HAS_CTRL ? cp_ph  : VSP_PHASE_W'(PHASE);
    // control reset also clears the stream side
    assign rst_w   = srst | (HAS_CTRL & cp_rst);

    // ------------------------------------------------------------
    // handshake terms
    // ------------------------------------------------------------
    vsp_slot_e            slot_r, slot_nxt;       // output slot
    logic                 in_ready_r, in_ready_nxt;
    logic [OUT_W-1:0]     dat_r, dat_nxt;
    logic                 sof_r, sof_nxt;
    logic                 eol_r, eol_nxt;
    logic [VSP_DIM_W-1:0] x_r, x_nxt;             // pixel in line
    logic [VSP_DIM_W-1:0] y_r, y_nxt;             // line in frame
    logic                 lerr_r, lerr_nxt;       // bad line length
    logic                 ferr_r, ferr_nxt;       // bad frame height
    logic                 in_take, out_take;
    logic [3*DATA_W-1:0]  rgb_w;
    logic [DATA_W-1:0]    sample_w;

    // beats move only with enable; reset handled in the flops
    assign in_take  = stream_clk_en & in_valid & in_ready_r;
    assign out_take = stream_clk_en & out_ready & (slot_r == VSP_SLOT_FULL);

    // upper pad bits of the input word are ignored
    assign sample_w = in_data[DATA_W-1:0];

    vsp_interp #(
        .DATA_W (DATA_W)
    ) u_interp (
        .clk    (clk),
        .rst    (rst_w),
        .take   (in_take),
        .sof    (in_frame_start_flag),
        .line_end_marker    (in_line_end_marker),
        .sample (sample_w),
        .phase  (cfg_ph),
        .rgb    (rgb_w)
    );

    // ------------------------------------------------------------
    // stream next-state
    // ------------------------------------------------------------
    // one slot and registered ready: at most one beat every two
    // cycles, traded for outputs that all come from flops
    always_comb
    begin
        slot_nxt     = slot_r;
        dat_nxt      = dat_r;
        sof_nxt      = sof_r;
        eol_nxt      = eol_r;
        x_nxt        = x_r;
        y_nxt        = y_r;
        lerr_nxt     = lerr_r;
        ferr_nxt     = ferr_r;
        in_ready_nxt = in_ready_r;
        if (stream_clk_en)
        begin
            unique case (slot_r)
                VSP_SLOT_EMPTY:
                begin
                    if (in_take)
                    begin
                        // zero fill above packed components
                        dat_nxt = OUT_W'(rgb_w);
                        // markers ride with their pixel
                        sof_nxt  = in_frame_start_flag;
                        eol_nxt  = in_line_end_marker;
                        // every accepted pixel produces one beat, even past cfg_len
                        slot_nxt = VSP_SLOT_FULL;
                    end
                end
                VSP_SLOT_FULL:
                begin
                    // held until the sink takes it
                    if (out_take)
                    begin
                        slot_nxt = VSP_SLOT_EMPTY;
                    end
                end
            endcase
            in_ready_nxt = (slot_nxt == VSP_SLOT_EMPTY);
            if (in_take)
            begin
                // geometry check against configured size
                if (in_frame_start_flag)
                begin
                    ferr_nxt = (y_r != '0) && (y_r != cfg_cnt);
                    y_nxt    = '0;
                end
                if (in_line_end_marker)
                begin
                    lerr_nxt = (x_r + 1'b1) != cfg_len;
                    x_nxt    = '0;
                    y_nxt    = (in_frame_start_flag ? '0 : y_r) + 1'b1;
                end
                else
                begin
                    x_nxt = x_r + 1'b1;
                end
                if (in_frame_start_flag && !in_line_end_marker)
                begin
                    x_nxt = VSP_DIM_W'(1);
                end
            end
        end
    end

    // registers; reset overrides the enable
    always_ff @(posedge clk)
    begin
        if (rst_w)
        begin
            slot_r     <= VSP_SLOT_EMPTY;
            in_ready_r <= 1'b0;
            dat_r      <= '0;
            sof_r      <= 1'b0;
            eol_r      <= 1'b0;
            x_r        <= '0;
            y_r        <= '0;
            lerr_r     <= 1'b0;
            ferr_r     <= 1'b0;
        end
        else
        begin
            slot_r     <= slot_nxt;
            in_ready_r <= in_ready_nxt;
            dat_r      <= dat_nxt;
            sof_r      <= sof_nxt;
            eol_r      <= eol_nxt;
            x_r        <= x_nxt;
            y_r        <= y_nxt;
            lerr_r     <= lerr_nxt;
            ferr_r     <= ferr_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign in_ready             = in_ready_r;
    assign out_data             = dat_r;
    assign out_valid            = (slot_r == VSP_SLOT_FULL);
    assign out_frame_start_flag = sof_r;
    assign out_line_end_marker  = eol_r;
    assign line_len_err         = lerr_r;
    assign frame_len_err        = ferr_r;

endmodule

// ===== vsp_top_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// stream port checker, top ports only
// ------------------------------------------------------------
module vsp_top_checker
#(
    parameter int DATA_W = 12,
    parameter int OUT_W  = 40
)
(
    input wire logic             clk,
    input wire logic             srst,
    input wire logic             stream_clk_en,
    input wire logic             in_valid,
    input wire logic             in_ready,
    input wire logic             in_frame_start_flag,
    input wire logic             in_line_end_marker,
    input wire logic [OUT_W-1:0] out_data,
    input wire logic             out_valid,
    input wire logic             out_ready,
    input wire logic             out_frame_start_flag,
    input wire logic             out_line_end_marker,
    input wire logic             ctl_clk,
    input wire logic             ctl_rst_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic take;   // input beat completes this edge
    assign take = in_valid && in_ready && stream_clk_en;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_pad_zero: assert property (out_valid |->
        out_data[OUT_W-1:3*DATA_W] == '0) else $error("pad bits set");
    a_out_hold: assert property (out_valid && !(out_ready && stream_clk_en)
        |=> out_valid && $stable(out_data) && $stable(out_frame_start_flag)
        && $stable(out_line_end_marker)) else $error("output moved");
    a_take_answer: assert property (take |=> out_valid && !in_ready)
        else $error("no answer to beat");
    a_no_spurious: assert property (!out_valid && !take |=> !out_valid)
        else $error("beat from nowhere");
    a_sof_copied: assert property (take |=>
        out_frame_start_flag == $past(in_frame_start_flag))
        else $error("start flag lost");
    a_eol_copied: assert property (take |=>
        out_line_end_marker == $past(in_line_end_marker))
        else $error("line end lost");
    a_en_freeze: assert property (!stream_clk_en |=> $stable(in_ready)
        && $stable(out_valid) && $stable(out_data)) else $error("not frozen");
    a_srst_clear: assert property (disable iff (1'b0)
        srst |=> !in_ready && !out_valid) else $error("reset ignored");
    a_ctl_rst_stream: assert property ((ctl_clk && !$past(ctl_clk)
        && !ctl_rst_n) |-> ##[1:6] (!in_ready && !out_valid))
        else $error("control reset missed stream");

    // main scenarios seen
    c_sof_beat: cover property (take && in_frame_start_flag);
    c_stall: cover property (out_valid && !out_ready ##1 out_ready);
    c_frozen: cover property (!stream_clk_en && out_valid);
endmodule

bind vsp_top vsp_top_checker #(.DATA_W(DATA_W), .OUT_W(OUT_W)) u_chk (
    .clk(clk), .srst(srst), .stream_clk_en(stream_clk_en),
    .in_valid(in_valid), .in_ready(in_ready),
    .in_frame_start_flag(in_frame_start_flag),
    .in_line_end_marker(in_line_end_marker), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready),
    .out_frame_start_flag(out_frame_start_flag),
    .out_line_end_marker(out_line_end_marker),
    .ctl_clk(ctl_clk), .ctl_rst_n(ctl_rst_n));

// ===== vsp_stream_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// upstream source and downstream sink
// ------------------------------------------------------------
module vsp_stream_model
#(
    parameter int IN_W  = 16,
    parameter int OUT_W = 40
)
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             stream_clk_en,
    input  wire logic             slow,
    output logic      [IN_W-1:0]  in_data,
    output logic                  in_valid,
    input  wire logic             in_ready,
    output logic                  in_frame_start_flag,
    output logic                  in_line_end_marker,
    input  wire logic [OUT_W-1:0] out_data,
    input  wire logic             out_valid,
    output logic                  out_ready,
    input  wire logic             out_frame_start_flag,
    input  wire logic             out_line_end_marker
);
    logic [OUT_W+1:0] rx_q[$];   // {sof, eol, data} as received

    initial
    begin
        in_data = '0;
        in_valid = 1'b0;
        in_frame_start_flag = 1'b0;
        in_line_end_marker = 1'b0;
        out_ready = 1'b0;
    end

    // offer one beat, held until taken; valid stays up for the next
    task automatic send(input logic [IN_W-1:0] d, input logic s,
                        input logic e);
        in_data <= d;
        in_frame_start_flag <= s;
        in_line_end_marker <= e;
        in_valid <= 1'b1;
        @(posedge clk);
        while (!(in_ready && stream_clk_en && !srst))
            @(posedge clk);
    endtask

    // release: lines show inverse, never the stale beat
    task automatic idle();
        in_valid <= 1'b0;
        in_data <= ~in_data;
        in_frame_start_flag <= ~in_frame_start_flag;
        in_line_end_marker <= ~in_line_end_marker;
    endtask

    // sink: slow answers a cycle after valid, else ready held high
    always @(posedge clk)
    begin
        out_ready <= slow ? (out_valid && !out_ready) : 1'b1;
        if (out_valid && out_ready && stream_clk_en && !srst)
            rx_q.push_back({out_frame_start_flag, out_line_end_marker,
                            out_data});
    end
endmodule

// ===== vsp_top_tb.sv
`timescale 1ns/10ps
module vsp_top_tb;
    import vsp_pkg::*;
    localparam int LEN   = 4;    // short lines keep the run brief
    localparam int CNT   = 2;
    localparam int IN_W  = 16;
    localparam int OUT_W = 40;

    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               en = 1'b1;
    logic               jit = 1'b0;   // random enable gaps
    logic               slow = 1'b0;  // sink answers late
    logic               ctl_clk_en = 1'b1;
    logic               ctl_rst_n = 1'b1;
    logic [12:0]        ctl_line_len = 13'h4;
    logic [12:0]        ctl_line_cnt = 13'h2;
    logic [1:0]         ctl_phase = 2'h0;
    logic [2:0]         div = 3'h0;    // control clock is clk / 8
    logic               ctl_clk;
    logic [IN_W-1:0]    in_data;
    logic               in_valid, in_ready, in_sof, in_eol;
    logic [OUT_W-1:0]   out_data;
    logic               out_valid, out_ready, out_sof, out_eol;
    logic               line_len_err, frame_len_err;
    logic [31:0]        seed = 32'hd626bf54;
    int                 mismatches = 0;
    int                 total_checks = 0;
    logic [35:0]        m_px = '0;    // model pixel
    logic               m_y = 1'b0;   // model row parity

    // ------------------------------------------------------------
    // clocks and stimulus helpers
    // ------------------------------------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) div <= div + 3'h1;
    assign ctl_clk = div[2];
    always @(posedge clk) en <= jit ? ((xs() & 32'h3) != 0) : 1'b1;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // flat colour: every site carries the same sample
    function automatic logic [OUT_W-1:0] exp_rgb(input logic [11:0] v);
        return {4'h0, v, v, v};
    endfunction

    task automatic chk_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [OUT_W-1:0] e,
                            input logic [OUT_W-1:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // one line of n pixels, then check what the sink got
    task automatic line(input int n, input bit sof, input bit rnd,
                        input logic [11:0] v, input bit cd);
        logic [11:0]      d;
        logic [OUT_W+1:0] got;
        logic [OUT_W-1:0] e_q[$];
        int               k;
        if (sof)
            m_y = 1'b0;
        for (int c = 0; c < n; c++)
        begin
            d = rnd ? 12'(xs()) : v;
            case ({m_y, c[0]})
                VSP_SITE_RED:  m_px[11:0]  = d;
                VSP_SITE_BLUE: m_px[35:24] = d;
                default:       m_px[23:12] = d;
            endcase
            e_q.push_back({4'h0, m_px});
            u_vsp_stream_model.send({4'h0, d}, sof && c == 0, c == n - 1);
        end
        m_y = ~m_y;
        u_vsp_stream_model.idle();
        k = 0;
        while (u_vsp_stream_model.rx_q.size() < n && k < 60)
        begin
            @(posedge clk);
            k++;
        end
        chk_bit("beats", 1'b1, u_vsp_stream_model.rx_q.size() == n);
        k = 0;
        while (u_vsp_stream_model.rx_q.size() > 0)
        begin
            got = u_vsp_stream_model.rx_q.pop_front();
            chk_bit("sof", sof && k == 0, got[OUT_W+1]);
            chk_bit("eol", k == n - 1, got[OUT_W]);
            chk_word("rgb", cd ? exp_rgb(v) : e_q.pop_front(),
                     got[OUT_W-1:0]);
            k++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------
    vsp_top #(.LINE_LEN(LEN), .LINE_CNT(CNT)) u_vsp_top (
        .clk(clk), .srst(srst), .stream_clk_en(en), .in_data(in_data),
        .in_valid(in_valid), .in_ready(in_ready),
        .in_frame_start_flag(in_sof), .in_line_end_marker(in_eol),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_frame_start_flag(out_sof), .out_line_end_marker(out_eol),
        .line_len_err(line_len_err), .frame_len_err(frame_len_err),
        .ctl_clk(ctl_clk), .ctl_clk_en(ctl_clk_en), .ctl_rst_n(ctl_rst_n),
        .ctl_line_len(ctl_line_len), .ctl_line_cnt(ctl_line_cnt),
        .ctl_phase(ctl_phase));

    vsp_stream_model #(.IN_W(IN_W), .OUT_W(OUT_W)) u_vsp_stream_model (
        .clk(clk), .srst(srst), .stream_clk_en(en), .slow(slow),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
        .in_frame_start_flag(in_sof), .in_line_end_marker(in_eol),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_frame_start_flag(out_sof), .out_line_end_marker(out_eol));

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        chk_bit("rst_ready", 1'b0, in_ready);
        srst <= 1'b0;
        @(posedge clk);
        #1 chk_bit("ready_up", 1'b1, in_ready);
        @(posedge clk);
        $display("test reset done");
        // second flat frame is free of reset leftovers
        for (int f = 0; f < 2; f++)
            for (int r = 0; r < CNT; r++)
                line(LEN, r == 0, 1'b0, 12'h5a3, f == 1);
        $display("test flat frame done");
        jit <= 1'b1;
        slow <= 1'b1;
        for (int f = 0; f < 3; f++)
            for (int r = 0; r < CNT; r++)
                line(LEN, r == 0, 1'b1, 12'h0, 1'b0);
        jit <= 1'b0;
        slow <= 1'b0;
        chk_bit("len_err", 1'b0, line_len_err);
        line(3, 1'b1, 1'b1, 12'h0, 1'b0);
        chk_bit("len_err", 1'b1, line_len_err);
        $display("test random frames done");
        ctl_line_len <= 13'h3;
        repeat (10) @(posedge clk);
        line(3, 1'b1, 1'b1, 12'h0, 1'b0);
        chk_bit("len_err", 1'b0, line_len_err);
        chk_bit("frm_err", 1'b1, frame_len_err);
        ctl_clk_en <= 1'b0;
        ctl_line_len <= 13'h5;
        repeat (10) @(posedge clk);
        line(3, 1'b1, 1'b1, 12'h0, 1'b0);
        chk_bit("len_err", 1'b0, line_len_err);
        ctl_rst_n <= 1'b0;
        m_px = '0;
        repeat (260) @(posedge clk);
        chk_bit("ctl_rst", 1'b0, in_ready);
        ctl_rst_n <= 1'b1;
        for (int k = 0; k < 40 && !in_ready; k++)
            @(posedge clk);
        line(LEN, 1'b1, 1'b1, 12'h0, 1'b0);
        chk_bit("len_err", 1'b0, line_len_err);
        ctl_line_len <= 13'h4;
        ctl_clk_en <= 1'b1;
        $display("test control port done");
        repeat (5) @(posedge clk);
        end_sim();
    end

    // watchdog, far past what the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule
